// ===== adc_readout_consts.vh
// Constants for the converter serial readout frame
`ifndef ADC_READOUT_CONSTS_VH
`define ADC_READOUT_CONSTS_VH

// ****************************************
// Frame shape
// ****************************************
`define BITS_PER_BYTE 8
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7
`define FRAME_BYTES 3
`define BYTE_IDX_W 2
`define BYTE_IDX_CFG 2'h0
`define BYTE_IDX_HIGH 2'h1
`define BYTE_IDX_LOW 2'h2
`define BYTE_IDX_DONE 2'h3

// ****************************************
// Result layout
// ****************************************
`define RESULT_W 12
`define RES_HI_MSB 11
`define RES_HI_LSB 7
`define RES_LO_MSB 6
`define RES_LO_LSB 0
`define HIGH_PAD 3'h0
`define LOW_FILL 1'h0

// ****************************************
// Pin synchroniser reset levels {din, sclk, cs_n}
// ****************************************
`define PIN_RESET 3'h1
`define BYTE_ZERO 8'h00

`endif

// ===== pin_sync.v
// Two-stage pin synchroniser with edge detection per bit
`timescale 1ns/1ps
module pin_sync
#(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b0}}
)
(
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] rise_out,
    output wire [WIDTH-1:0] fall_out
);

    genvar i;

    // ****************************************
    // One synchroniser and edge detector per pin
    // ****************************************
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg stage1;
            reg stage2;
            reg prev;

            // Stage1 feeds stage2 only; prev holds last synced level
            always @(posedge clk_in)
            begin
                if (!resetn_in)
                begin
                    stage1 <= RESET_LEVEL[i];
                    stage2 <= RESET_LEVEL[i];
                    prev <= RESET_LEVEL[i];
                end
                else if (ce_in)
                begin
                    stage1 <= pin_in[i];
                    stage2 <= stage1;
                    prev <= stage2;
                end
            end

            // Edges seen on the synced level
            assign level_out[i] = stage2;
            assign rise_out[i] = stage2 & ~prev;
            assign fall_out[i] = ~stage2 & prev;
        end
    endgenerate

endmodule

// ===== adc_serial_result_readout.v
// Device-side serial readout frame of a 12-bit converter result
//
// Summary of operation
// - Each byte moves most significant bit first over eight serial clock periods driven by the host.
// - A full result is read in one frame of three 8-bit transfers while chip select stays low.
// - In the second transfer result bits 11 to 7 sit in the five low positions and the upper three are zero.
// - In the third transfer result bits 6 to 0 sit in the seven upper positions and the last bit is filler.
`timescale 1ns/1ps
`include "adc_readout_consts.vh"
module adc_serial_result_readout
(
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    input wire cs_n_in,
    input wire sclk_in,
    input wire din_in,
    output reg dout_out,
    output wire dout_oe_out,
    input wire [`RESULT_W-1:0] result_in,
    output reg [`BITS_PER_BYTE-1:0] config_out,
    output reg config_valid_out,
    output reg [`RESULT_W-1:0] result_sent_out,
    output reg frame_done_out,
    output wire frame_active_out
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    wire [2:0] pin_level;
    wire [2:0] pin_rise;
    wire [2:0] pin_fall;

    // Bit 0 chip select, bit 1 serial clock, bit 2 data in
    pin_sync
    #(
        .WIDTH(3),
        .RESET_LEVEL(`PIN_RESET)
    )
    u_pin_sync
    (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .pin_in({din_in, sclk_in, cs_n_in}),
        .level_out(pin_level),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // ****************************************
    // Edge qualification
    // ****************************************
    wire cs_n_sync;
    wire sclk_rise;
    wire sclk_fall;
    wire din_sync;
    wire cs_rise;

    // Chip select gates the serial clock edges
    assign cs_n_sync = pin_level[0];
    assign cs_rise = pin_rise[0];
    assign sclk_rise = pin_rise[1] & ~cs_n_sync;
    assign sclk_fall = pin_fall[1] & ~cs_n_sync;
    assign din_sync = pin_level[2];

    // ****************************************
    // Frame position
    // ****************************************
    reg [`BIT_CNT_W-1:0] bit_cnt;
    reg [`BYTE_IDX_W-1:0] byte_idx;
    reg [`BITS_PER_BYTE-1:0] rx_shift;
    reg [`RESULT_W-1:0] held_result;
    wire byte_end;
    wire [`BITS_PER_BYTE-1:0] rx_byte;

    // Eighth rising edge closes a byte
    assign byte_end = sclk_rise && (bit_cnt == `BIT_CNT_LAST);
    assign rx_byte = {rx_shift[`BITS_PER_BYTE-2:0], din_sync};
    assign frame_active_out = ~cs_n_sync;

    // Bit and byte counting, restarted whenever chip select is high
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            bit_cnt <= {`BIT_CNT_W{1'b0}};
            byte_idx <= `BYTE_IDX_CFG;
        end
        else if (ce_in)
        begin
            if (cs_n_sync)
            begin
                bit_cnt <= {`BIT_CNT_W{1'b0}};
                byte_idx <= `BYTE_IDX_CFG;
            end
            else if (sclk_rise)
            begin
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == `BIT_CNT_LAST && byte_idx != `BYTE_IDX_DONE)
                begin
                    byte_idx <= byte_idx + 2'h1;
                end
            end
        end
    end

    // ****************************************
    // Receive shift register
    // ****************************************

    // Host data collected MSB first, cleared so an aborted frame leaves no bits behind
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            rx_shift <= `BYTE_ZERO;
        end
        else if (ce_in)
        begin
            if (cs_n_sync)
            begin
                rx_shift <= `BYTE_ZERO;
            end
            else if (sclk_rise)
            begin
                rx_shift <= rx_byte;
            end
        end
    end

    // ****************************************
    // Configuration capture and result hold
    // ****************************************
    // First byte of the frame is the configuration word; result frozen here
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            config_out <= `BYTE_ZERO;
            config_valid_out <= 1'b0;
            held_result <= {`RESULT_W{1'b0}};
        end
        else if (ce_in)
        begin
            config_valid_out <= 1'b0;
            if (byte_end && byte_idx == `BYTE_IDX_CFG)
            begin
                config_out <= rx_byte;
                config_valid_out <= 1'b1;
                held_result <= result_in;
            end
        end
    end

    // ****************************************
    // Frame completion
    // ****************************************

    // Third byte finished: whole result went out
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            result_sent_out <= {`RESULT_W{1'b0}};
            frame_done_out <= 1'b0;
        end
        else if (ce_in)
        begin
            frame_done_out <= 1'b0;
            if (byte_end && byte_idx == `BYTE_IDX_LOW)
            begin
                result_sent_out <= held_result;
                frame_done_out <= 1'b1;
            end
        end
    end

    // ****************************************
    // Output data
    // ****************************************
    reg [`BITS_PER_BYTE-1:0] tx_byte;

    // Byte presented in the current transfer
    always @*
    begin
        case (byte_idx)
            `BYTE_IDX_HIGH:
                tx_byte = {`HIGH_PAD, held_result[`RES_HI_MSB:`RES_HI_LSB]};
            `BYTE_IDX_LOW:
                tx_byte = {held_result[`RES_LO_MSB:`RES_LO_LSB], `LOW_FILL};
            default:
                tx_byte = `BYTE_ZERO;
        endcase
    end

    // Launch on falling edge so the host samples on the rising one
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            dout_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (cs_n_sync || cs_rise)
            begin
                dout_out <= 1'b0;
            end
            else if (sclk_fall)
            begin
                dout_out <= tx_byte[`BIT_CNT_LAST - bit_cnt];
            end
        end
    end

    // Drive the data line only inside a frame
    assign dout_oe_out = ~cs_n_sync;

endmodule

// ===== readout_sva.sv
// Port assertions for the serial readout frame
`timescale 1ns/1ps
module readout_sva
(
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    input wire cs_n_in,
    input wire sclk_in,
    input wire din_in,
    input wire dout_out,
    input wire dout_oe_out,
    input wire [11:0] result_in,
    input wire [7:0] config_out,
    input wire config_valid_out,
    input wire [11:0] result_sent_out,
    input wire frame_done_out,
    input wire frame_active_out
);
    // ****
    // Frame checks
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_tail;
        ##[300:1000] frame_done_out;
    endsequence
    property p_frame; config_valid_out |-> s_tail; endproperty
    a_frame: assert property (p_frame) else $error("no frame end after config");
    property p_cfg_pulse; config_valid_out |=> !config_valid_out; endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("config pulse too long");
    property p_done_pulse; frame_done_out |=> !frame_done_out; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
    // Both select views trail the pin by the two synchroniser stages
    property p_oe; $past(ce_in) && $past(ce_in, 2) |-> dout_oe_out == !$past(cs_n_in, 2); endproperty
    a_oe: assert property (p_oe) else $error("enable does not follow select");
    property p_active; $past(ce_in) && $past(ce_in, 2) |-> frame_active_out == !$past(cs_n_in, 2); endproperty
    a_active: assert property (p_active) else $error("active does not follow select");
    property p_idle; !frame_active_out && !$past(frame_active_out) |-> !dout_out; endproperty
    a_idle: assert property (p_idle) else $error("data out while idle");
    property p_cfg_upd; $changed(config_out) |-> config_valid_out || $past(config_valid_out); endproperty
    a_cfg_upd: assert property (p_cfg_upd) else $error("config moved without pulse");
    property p_res_upd; $changed(result_sent_out) |-> frame_done_out || $past(frame_done_out); endproperty
    a_res_upd: assert property (p_res_upd) else $error("result moved without pulse");
    property p_res; frame_done_out |-> ##[0:1] result_sent_out == result_in; endproperty
    a_res: assert property (p_res) else $error("sent result wrong");
    property p_done_in; frame_done_out |-> frame_active_out; endproperty
    a_done_in: assert property (p_done_in) else $error("done outside frame");
endmodule

// ===== spi_host_model.sv
// Behavioural host serial master on four plain lines
`timescale 1ns/1ps
module spi_host_model
(
    output reg cs_n_out,
    output reg sclk_out,
    output reg mosi_out,
    input wire miso_in
);
    // Idle levels, clock stands low
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    // Select edge with settle gap; whole-cycle delays keep pin edges on clk_in falling edges
    task select(input logic level);
        #60 cs_n_out = level;
        #125;
    endtask
    // One byte of 125 ns periods, 65 low and 60 high: launch while low, sample on the rise
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_out = tx[i];
            #65 sclk_out = 1'b1;
            rx[i] = miso_in;
            #60 sclk_out = 1'b0;
        end
        mosi_out = ~mosi_out;
        #100;
    endtask
endmodule

// ===== adc_serial_result_readout_test.sv
// Self-checking bench for the serial readout frame
`timescale 1ns/1ps
module adc_serial_result_readout_test;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ce_in = 1'b1;
    logic [11:0] result_in = 12'h000;
    logic [11:0] n_cfg = 12'h000;
    logic [11:0] n_done = 12'h000;
    int num_errors = 0;
    int total_checks = 0;
    wire cs_n, sclk, din, dout, oe, cfg_v, done, active;
    wire [7:0] cfg;
    wire [11:0] sent;
    // Released data line reads back the inverse of its last level
    wire miso = oe ? dout : ~dout;
    spi_host_model u_host(.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(din), .miso_in(miso));
    adc_serial_result_readout u_dut(.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .din_in(din), .dout_out(dout), .dout_oe_out(oe), .result_in(result_in), .config_out(cfg),
        .config_valid_out(cfg_v), .result_sent_out(sent), .frame_done_out(done), .frame_active_out(active));
    // Clock and pulse counters
    initial forever #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) n_cfg <= n_cfg + (cfg_v === 1'b1);
    always @(posedge clk_in) n_done <= n_done + (done === 1'b1);
    task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One frame of nb bytes, active checked after select, then all other comparisons
    task frame(input logic [7:0] c, input logic [11:0] r, input int nb);
        logic [7:0] b [0:3];
        logic [15:0] w;
        logic [11:0] c0, d0;
        c0 = n_cfg;
        d0 = n_done;
        @(negedge clk_in) result_in = r;
        u_host.select(1'b0);
        chk("active", 12'h001, {11'h000, active});
        for (int i = 0; i < nb; i++) u_host.xfer(i == 0 ? c : 8'hA5, b[i]);
        u_host.select(1'b1);
        w = {b[1] & 8'h1F, b[2] & 8'hFE} >> 1;
        chk("idle", 12'h000, {11'h000, active});
        chk("config", {4'h0, c}, {4'h0, cfg});
        chk("byte2", {7'h00, r[11:7]}, {4'h0, b[1]});
        chk("byte3", {4'h0, r[6:0], 1'b0}, {4'h0, b[2]});
        chk("joined", r, w[11:0]);
        chk("sent", r, sent);
        chk("cfg_pulses", 12'h001, n_cfg - c0);
        chk("done_pulses", 12'h001, n_done - d0);
        if (nb > 3) chk("byte4", 12'h000, {4'h0, b[3]});
    endtask
    task t_channel_zero;
        frame(8'h08, 12'hA5C, 3);
        $display("channel zero done");
    endtask
    task t_back_to_back;
        frame(8'hF7, 12'hFFF, 3);
        frame(8'h08, 12'h000, 3);
        $display("back to back done");
    endtask
    task t_extra_byte;
        frame(8'h08, 12'h3C1, 4);
        $display("extra byte done");
    endtask
    // Clock enable low: a whole frame on the pins must leave no trace
    task t_freeze;
        logic [7:0] junk;
        logic [11:0] c0, d0;
        c0 = n_cfg;
        d0 = n_done;
        @(negedge clk_in) ce_in = 1'b0;
        u_host.select(1'b0);
        for (int i = 0; i < 3; i++) u_host.xfer(8'h5A, junk);
        u_host.select(1'b1);
        chk("frozen_config", 12'h008, {4'h0, cfg});
        chk("frozen_pulses", 12'h000, (n_cfg - c0) | (n_done - d0));
        chk("frozen_enable", 12'h000, {10'h000, oe, active});
        @(negedge clk_in) ce_in = 1'b1;
        repeat (3) @(negedge clk_in);
        frame(8'h08, 12'h5A5, 3);
        $display("clock enable hold done");
    endtask
    // Reset between frames clears the held outputs
    task t_mid_reset;
        @(negedge clk_in) resetn_in = 1'b0;
        repeat (3) @(negedge clk_in);
        resetn_in = 1'b1;
        @(negedge clk_in);
        chk("reset_config", 12'h000, {4'h0, cfg});
        chk("reset_sent", 12'h000, sent);
        chk("reset_data", 12'h000, {10'h000, oe, dout});
        repeat (2) @(negedge clk_in);
        frame(8'h08, 12'h7E3, 3);
        $display("mid reset done");
    endtask
    // Reset, tests and watchdog; the tests need about 30 us of the 100 us limit
    initial
    begin
        repeat (12) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_channel_zero;
        t_back_to_back;
        t_extra_byte;
        t_freeze;
        t_mid_reset;
        print_verdict;
    end
    initial
    begin
        #100000;
        num_errors++;
        print_verdict;
    end
endmodule
bind adc_serial_result_readout readout_sva u_sva(.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .cs_n_in(cs_n_in), .sclk_in(sclk_in), .din_in(din_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .result_in(result_in), .config_out(config_out), .config_valid_out(config_valid_out),
    .result_sent_out(result_sent_out), .frame_done_out(frame_done_out), .frame_active_out(frame_active_out));
